// file: sssrw_host.sv
// host model: kicks the watchdog or floats its pin
`timescale 1ns/100ps
module sssrw_host
(
  // control and pin
  input wire logic i_clk,
  input wire logic i_en,
  input wire logic i_float,
  output logic o_kick = 1'h0,
  output logic o_driven
);
  // kick each edge; a floating pin wanders
  always @(posedge i_clk)
    o_kick <= o_kick ^ (i_en | i_float);
  assign o_driven = ~i_float;
endmodule : sssrw_host

// file: sssrw_map.svh
// timing and level constants for the supply supervisor, reset and watchdog
`ifndef SSSRW_MAP_SVH
`define SSSRW_MAP_SVH

// clock rate
`define SSSRW_CLK_HZ 10000000
// reset release delay, nominal, in ms
`define SSSRW_RESET_DELAY_MS 200
// least reset pulse, in ms
`define SSSRW_RESET_MIN_MS 140
// watchdog period, in ms
`define SSSRW_WDOG_MS 1600
// power-fail reference, in mV (compared off-chip)
`define SSSRW_FAIL_REF_MV 1220
// cycle counts derived from the rate
`define SSSRW_RESET_DELAY_CYC ((`SSSRW_CLK_HZ / 1000) * `SSSRW_RESET_DELAY_MS)
`define SSSRW_WDOG_CYC ((`SSSRW_CLK_HZ / 1000) * `SSSRW_WDOG_MS)

`endif

// file: sssrw_pkg.sv
// types for the supply supervisor, reset and watchdog
package sssrw_pkg;

  // sampled analog comparator levels
  typedef struct packed {
    logic supply_below;
    logic supply_min_ok;
    logic fail_below;
  } sssrw_sense_t;

  // reset sequencer states
  typedef enum logic [1:0] {
    SSSRW_HOLD,
    SSSRW_DELAY,
    SSSRW_RUN
  } sssrw_state_t;

endpackage : sssrw_pkg

// file: sssrw_top.sv
// supply supervisor: reset sequencer, watchdog, power-fail flag
`timescale 1ns/100ps
`include "sssrw_map.svh"

module sssrw_top
  #(
    parameter int unsigned RESET_DELAY_CYC = `SSSRW_RESET_DELAY_CYC,
    parameter int unsigned WDOG_CYC = `SSSRW_WDOG_CYC
  )
  (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // comparator levels from the analog front end
    input wire sssrw_pkg::sssrw_sense_t i_sense,
    // host side pins
    input wire logic i_push_reset_in_n,
    input wire logic i_watchdog_kick_in,
    input wire logic i_watchdog_kick_driven,
    // outputs
    output logic o_reset_n,
    output logic o_watchdog_expired_out_n,
    output logic o_fail_flag_out_n
  );

  // ==========================================================
  // shared decode
  // ==========================================================
  // terminal count test used by the reset delay and the watchdog;
  // a >= compare, not ==, so a count that somehow overshoots still
  // ends instead of running the whole 32-bit range once more
  function automatic logic count_done
  (
    input logic [31:0] count,
    input logic [31:0] limit
  );
    begin
      count_done = (count >= (limit - 32'h1));
    end
  endfunction : count_done

  // ==========================================================
  // reset sequencer
  // ==========================================================
  sssrw_pkg::sssrw_state_t state_reg;
  sssrw_pkg::sssrw_state_t state_next;
  logic [31:0] delay_reg;
  logic [31:0] delay_next;
  logic reset_n_reg;
  logic reset_n_next;
  logic hold_cause;

  // limitation: below the minimum supply the real pin is undefined;
  // supply_min_ok is left unread and the model simply keeps reset low
  // push low holds
  // fail flag strap path
  // any cause that keeps reset low right now; the push input is the one
  // path shared by a button, a strapped expiry and a strapped fail flag
  assign hold_cause = i_sense.supply_below | ~i_push_reset_in_n;

  // next state of the reset sequencer
  always_comb
  begin
    state_next = state_reg;
    delay_next = delay_reg;
    reset_n_next = 1'b0;
    case (state_reg)
      sssrw_pkg::SSSRW_HOLD:
      begin
        delay_next = 32'h0;
        if (!hold_cause)
          state_next = sssrw_pkg::SSSRW_DELAY;
      end
      sssrw_pkg::SSSRW_DELAY:
      begin
        if (hold_cause)
        begin
          state_next = sssrw_pkg::SSSRW_HOLD;
          delay_next = 32'h0;
        end
        else if (count_done(delay_reg, RESET_DELAY_CYC))
        begin
          state_next = sssrw_pkg::SSSRW_RUN;
          reset_n_next = 1'b1;
        end
        else
          delay_next = delay_reg + 32'h1;
      end
      sssrw_pkg::SSSRW_RUN:
      begin
        reset_n_next = 1'b1;
        if (hold_cause)
        begin
          state_next = sssrw_pkg::SSSRW_HOLD;
          reset_n_next = 1'b0;
        end
      end
      default:
        state_next = sssrw_pkg::SSSRW_HOLD;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      state_reg <= sssrw_pkg::SSSRW_HOLD;
      delay_reg <= 32'h0;
      reset_n_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      delay_reg <= delay_next;
      reset_n_reg <= reset_n_next;
    end
  end

  // ==========================================================
  // watchdog
  // ==========================================================
  logic [31:0] wdog_reg;
  logic [31:0] wdog_next;
  logic kick_last_reg;
  logic kick_last_next;
  logic expired_n_reg;
  logic expired_n_next;

  // next watchdog count; a timeout holds until a kick, a reset or an undriven kick pin
  always_comb
  begin
    wdog_next = wdog_reg;
    kick_last_next = i_watchdog_kick_in;
    expired_n_next = expired_n_reg;
    if (!reset_n_reg || !i_watchdog_kick_driven)
    begin
      wdog_next = 32'h0;
      expired_n_next = 1'b1;
    end
    else if (i_watchdog_kick_in != kick_last_reg)
    begin
      wdog_next = 32'h0;
      expired_n_next = 1'b1;
    end
    // timeout latches low; the count stops at WDOG_CYC - 1 so it never wraps
    // and no second timeout can be mistaken for a fresh one
    else if (count_done(wdog_reg, WDOG_CYC))
      expired_n_next = 1'b0;
    else
      wdog_next = wdog_reg + 32'h1;
    if (i_sense.supply_below)
      expired_n_next = 1'b0;
  end

  // watchdog registers
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      wdog_reg <= 32'h0;
      kick_last_reg <= 1'b0;
      expired_n_reg <= 1'b1;
    end
    else
    begin
      wdog_reg <= wdog_next;
      kick_last_reg <= kick_last_next;
      expired_n_reg <= expired_n_next;
    end
  end

  // ==========================================================
  // power-fail flag and outputs
  // ==========================================================
  logic fail_n_reg;
  logic fail_n_next;

  always_comb
    fail_n_next = ~i_sense.fail_below;

  // flag register, no path to the reset logic; any reset action on a
  // fail comes only through an outside strap to the push input
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      fail_n_reg <= 1'b0;
    else
      fail_n_reg <= fail_n_next;
  end

  // every pin comes straight from a flip-flop, so no comparator glitch
  // can reach the host between clock edges
  // active low reset pin
  assign o_reset_n = reset_n_reg;
  assign o_watchdog_expired_out_n = expired_n_reg;
  assign o_fail_flag_out_n = fail_n_reg;

endmodule : sssrw_top

// file: sssrw_top_sva.sv
// checker for reset, expiry and fail flag
`timescale 1ns/100ps
module sssrw_top_sva
  #(parameter int unsigned RESET_DELAY_CYC = 20,
    parameter int unsigned WDOG_CYC = 50)
  (
    // watched pins
    input wire logic i_clk,
    input wire logic i_reset,
    input wire sssrw_pkg::sssrw_sense_t i_sense,
    input wire logic i_push_reset_in_n,
    input wire logic i_watchdog_kick_in,
    input wire logic i_watchdog_kick_driven,
    input wire logic o_reset_n,
    input wire logic o_watchdog_expired_out_n,
    input wire logic o_fail_flag_out_n
  );
  int unsigned q_reg;
  logic sb;
  logic ok;
  assign sb = i_sense.supply_below;
  assign ok = o_watchdog_expired_out_n;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // quiet cycles; saturates so it never wraps
  always_ff @(posedge i_clk)
    if (i_reset | sb | ~i_push_reset_in_n)
      q_reg <= 0;
    else if (q_reg < RESET_DELAY_CYC + 3)
      q_reg <= q_reg + 1;
  a_cause_asserts: assert property
    ((sb | ~i_push_reset_in_n) |=> !o_reset_n) else $error("no reset");
  a_release_exact: assert property
    ($rose(o_reset_n) |-> q_reg == RESET_DELAY_CYC + 1) else $error("late");
  a_no_early: assert property
    (o_reset_n |-> q_reg >= RESET_DELAY_CYC + 1) else $error("early");
  a_wdog_cleared: assert property
    ((!o_reset_n | !i_watchdog_kick_driven) & !sb |=> ok) else $error("wd");
  a_brown_expiry: assert property
    (sb |=> !ok) else $error("expiry high");
  a_kick_clears: assert property
    ($changed(i_watchdog_kick_in) & i_watchdog_kick_driven & o_reset_n
      & !sb |-> ##[1:2] ok) else $error("kick lost");
  a_expiry_cause: assert property
    ($fell(ok) & !$past(sb) |-> $past(i_watchdog_kick_driven))
    else $error("bad expiry");
  a_fail_follow: assert property
    (!$past(i_reset) |-> o_fail_flag_out_n == !$past(i_sense.fail_below))
    else $error("flag");
  cover property ($rose(o_reset_n));
  cover property ($fell(ok));
  cover property ($fell(o_fail_flag_out_n));
endmodule : sssrw_top_sva
bind sssrw_top sssrw_top_sva #(.RESET_DELAY_CYC(RESET_DELAY_CYC),
  .WDOG_CYC(WDOG_CYC)) i_sssrw_top_sva (.*);

// file: test_sssrw_top.sv
// bench for the supply supervisor
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
  $display("wrong value at %0t: output", $time); end end
module test_sssrw_top;
  localparam int D = 20;
  localparam int W = 50;
  logic i_clk = 1'h0;
  logic i_reset = 1'h1;
  sssrw_pkg::sssrw_sense_t i_sense = 3'h6;
  logic btn_n = 1'h1;
  logic en = 1'h1;
  logic flt = 1'h0;
  logic [1:0] strap = 2'h0;
  logic i_push_reset_in_n, i_watchdog_kick_in, i_watchdog_kick_driven;
  logic o_reset_n, o_watchdog_expired_out_n, o_fail_flag_out_n;
  int errors = 0;
  int cmp_count = 0;
  int n;
  // strap feeds an output back to push
  assign i_push_reset_in_n = strap[0] ? o_watchdog_expired_out_n :
    strap[1] ? o_fail_flag_out_n : btn_n;
  initial forever #50 i_clk = ~i_clk;
  sssrw_top #(.RESET_DELAY_CYC(D), .WDOG_CYC(W)) i_sssrw_top (.*);
  sssrw_host i_sssrw_host (.i_clk(i_clk), .i_en(en), .i_float(flt),
    .o_kick(i_watchdog_kick_in), .o_driven(i_watchdog_kick_driven));
  // count cycles to release, bounded
  task automatic rel(input int k);
    repeat (k) @(negedge i_clk);
    for (n = 0; o_reset_n !== 1'h1 && n < 99; n++)
      @(negedge i_clk);
  endtask : rel
  task automatic t_pwr();
    repeat (3) @(negedge i_clk);
    `CHK(o_reset_n, 1'h0)
    `CHK(o_watchdog_expired_out_n, 1'h0)
    `CHK(o_fail_flag_out_n, 1'h1)
    i_sense.supply_below = 1'h0;
    rel(0);
    `CHK(n, D + 1)
    i_sense.supply_below = 1'h1;
    @(negedge i_clk);
    `CHK(o_reset_n, 1'h0)
    i_sense.supply_below = 1'h0;
    repeat (D / 2) @(negedge i_clk);
    `CHK(o_reset_n, 1'h0)
    i_sense.supply_below = 1'h1;
    @(negedge i_clk);
    i_sense.supply_below = 1'h0;
    rel(0);
    `CHK(n, D + 1)
    btn_n = 1'h0;
    repeat (30) @(negedge i_clk);
    `CHK(o_reset_n, 1'h0)
    btn_n = 1'h1;
    rel(0);
    `CHK(n, D + 1)
    $display("reset done");
  endtask : t_pwr
  task automatic t_wd();
    en = 1'h0;
    rel(W + 4);
    `CHK(o_watchdog_expired_out_n, 1'h0)
    en = 1'h1;
    rel(3);
    `CHK(o_watchdog_expired_out_n, 1'h1)
    {flt, en} = 2'h2;
    rel(W + 9);
    `CHK(o_watchdog_expired_out_n, 1'h1)
    {flt, strap} = 3'h1;
    rel(W + 4);
    `CHK(n, D)
    $display("watchdog done");
  endtask : t_wd
  task automatic t_fail();
    {en, strap, i_sense.fail_below} = 4'hD;
    repeat (2) @(negedge i_clk);
    `CHK(o_fail_flag_out_n, 1'h0)
    `CHK(o_reset_n, 1'h0)
    i_sense.fail_below = 1'h0;
    rel(0);
    `CHK(n, D + 2)
    `CHK(o_fail_flag_out_n, 1'h1)
    $display("fail done");
  endtask : t_fail
  task automatic complete_run();
    $display("errors %0d checks %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run
  initial
  begin
    repeat (6) @(negedge i_clk);
    i_reset = 1'h0;
    t_pwr();
    t_wd();
    t_fail();
    complete_run();
  end
  // hang guard
  initial
  begin
    #200000;
    errors++;
    complete_run();
  end
endmodule : test_sssrw_top
